// >>> design/uvt_pkg.sv
// package for the definite-time undervoltage trip block: register map,
// setting ranges and reset values, timing constants and carrier types.
// assumes magnitudes arrive as unsigned fixed point percent of rated voltage.
package uvt_pkg;

  // register byte addresses on the plain register port
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_START_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_BLOCK_FLOOR = 8'h08;
  localparam logic [7:0] ADDR_DROPOUT     = 8'h0C;
  localparam logic [7:0] ADDR_DELAY       = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1C;

  // control register fields
  localparam int CTRL_OPER_LSB    = 0;
  localparam int CTRL_START_ONLY  = 2;
  localparam int CTRL_LINE_LINE   = 3;

  // status register fields
  localparam int STAT_STARTED_LSB = 0;
  localparam int STAT_TRIPPED_LSB = 3;
  localparam int STAT_GEN_START   = 6;
  localparam int STAT_GEN_TRIP    = 7;
  localparam int STAT_BLOCKED     = 8;

  // interrupt event bits
  localparam int IRQ_W            = 3;
  localparam int IRQ_START_RISE   = 0;
  localparam int IRQ_TRIP_RISE    = 1;
  localparam int IRQ_START_FALL   = 2;

  // setting ranges and defaults, percent or milliseconds
  localparam logic [7:0]  START_MIN    = 8'h1E;
  localparam logic [7:0]  START_MAX    = 8'h82;
  localparam logic [7:0]  START_DEF    = 8'h5A;
  localparam logic [7:0]  FLOOR_MIN    = 8'h00;
  localparam logic [7:0]  FLOOR_MAX    = 8'h14;
  localparam logic [7:0]  FLOOR_DEF    = 8'h0A;
  localparam logic [7:0]  DROP_MIN     = 8'h01;
  localparam logic [7:0]  DROP_MAX     = 8'h0A;
  localparam logic [7:0]  DROP_DEF     = 8'h05;
  localparam logic [15:0] DELAY_MIN    = 16'h0032;
  localparam logic [15:0] DELAY_MAX    = 16'hEA60;
  localparam logic [15:0] DELAY_DEF    = 16'h0064;
  localparam logic [31:0] PCT_FULL     = 32'h0000_0064;

  // magnitude format: fraction bits below the percent point
  localparam int MAG_FRAC = 8;

  // processing tick: 1 ms from a 125 MHz clock, rounded up
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // operation selector choices
  typedef enum logic [1:0] {
    OPER_OFF,
    OPER_ONE_OF_THREE,
    OPER_TWO_OF_THREE,
    OPER_ALL
  } uvt_oper_e;

  // per-phase decision state
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_RUN,
    PH_TRIP
  } uvt_phase_e;

  // software settings as one carrier
  typedef struct packed {
    uvt_oper_e   operation_selector;
    logic        start_indication_only;
    logic        line_to_line;
    logic [7:0]  start_level_pct;
    logic [7:0]  blocking_floor_pct;
    logic [7:0]  dropout_ratio_pct;
    logic [15:0] trip_delay_ms;
  } uvt_cfg_s;

  // exported decision flags; per-phase trips stay inside
  typedef struct packed {
    logic [2:0] phase_started;
    logic       general_start_out;
    logic       general_trip_out;
  } uvt_flags_s;

endpackage : uvt_pkg

// >>> design/uvt_trip.sv
// definite-time undervoltage trip decision with its register file.
// assumes phase magnitudes and the block input come from logic on clk_i,
// so neither is synchronised; magnitudes are unsigned percent with
// uvt_pkg::MAG_FRAC fraction bits.
`timescale 1ns/10ps
`default_nettype none

// Function
// R1: phase starts when magnitude below start level and above blocking floor.
// R2: general start set when any phase has started.
// R3: trip only after full delay and only when trips are enabled.
// R4: each phase times separately; status shows started and tripped per phase.
// R5: operation selector off, one, two or all of three; resets to off.
// R6: start level percent, 30 to 130 step 1, default 90.
// R7: below blocking floor no start; floor 0 to 20, default 10.
// R8: drop-out ratio percent, 1 to 10 step 1, default 5.
// R9: start-only bit; 0 default allows trips, 1 gives starts only.
// R10: trip delay milliseconds, 50 to 60000 step 1, default 100.
// R11: start and trip per phase; per-phase trips not exported as outputs.
// R12: phase-to-phase evaluation by default, channels read as L12, L23, L31; line_to_line is only stored, the decision ignores it.
// R13: user logic drives the block input; asserted disables the whole function.
// R14: off keeps outputs low; else general trip needs one, two or three timers.
// R15: started phase drops out and clears timer above raised start level.
// R16: timers step on 1 ms tick from the clock, cleared on reset.
module uvt_trip #(
  parameter int MAG_W       = 16,
  parameter int TICK_CYCLES = uvt_pkg::TICK_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [MAG_W-1:0]   phase_a_magnitude_i,
  input  wire logic [MAG_W-1:0]   phase_b_magnitude_i,
  input  wire logic [MAG_W-1:0]   phase_c_magnitude_i,
  input  wire logic               function_block_in_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [31:0]        wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output var  logic [31:0]        rdata_o,
  output var  uvt_pkg::uvt_flags_s flags_o,
  output var  logic               irq_o
);
  import uvt_pkg::*;

  // tick counter width follows the divide ratio;
  // a short TICK_CYCLES keeps simulation fast,
  // the default gives the real 1 ms step.
  // counter wraps at TICK_LAST, one pulse per wrap
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // settings are narrow, so one 16 bit clamp
  // serves every range; callers zero extend
  // and cut the result back to width.
  // clamp a written setting into its legal range
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : clamp16

  // percent setting scaled into the magnitude's fixed point, 32 bits wide
  function automatic logic [31:0] level32(input logic [7:0] pct);
    return {24'h00_0000, pct} << MAG_FRAC;
  endfunction : level32

  // count of set bits among three
  function automatic logic [1:0] count3(input logic [2:0] v);
    return {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction : count3

  // state of the block: settings, phase
  // machines and timers, tick, interrupts;
  // everything below resets asynchronously
  uvt_cfg_s              cfg_reg;
  uvt_phase_e            phase_reg [3];
  logic [15:0]           timer_reg [3];
  logic [TICK_W-1:0]     tick_cnt_reg;
  logic                  tick_reg;
  logic [IRQ_W-1:0]      irq_status_reg;
  logic [IRQ_W-1:0]      irq_mask_reg;
  logic [IRQ_W-1:0]      irq_status_next;
  logic [IRQ_W-1:0]      events;
  logic [2:0]            started;
  logic [2:0]            tripped;
  logic [2:0]            pickup;
  logic [2:0]            hold_ok;
  logic [MAG_W-1:0]      mag [3];
  logic                  inhibit;
  logic                  gen_start_next;
  logic                  gen_trip_next;
  logic [1:0]            trips_needed;
  logic [31:0]           read_word;

  assign mag[0] = phase_a_magnitude_i;
  assign mag[1] = phase_b_magnitude_i;
  assign mag[2] = phase_c_magnitude_i;

  // one shared inhibit keeps state and flags
  // consistent: both clear in the same edge,
  // so no stale start survives a block.
  // whole function held quiet by the block input or the off selection
  assign inhibit = function_block_in_i || (cfg_reg.operation_selector == OPER_OFF); // R13 R14

  // a setting change takes effect at once,
  // also on a running timer; the user must
  // block the function to retune safely.
  // settings registers; out-of-range writes clamp so the decision never
  // sees an illegal threshold
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg.operation_selector    <= OPER_OFF;   // R5
      cfg_reg.start_indication_only <= 1'b0;       // R9
      cfg_reg.line_to_line          <= 1'b1;       // R12
      cfg_reg.start_level_pct       <= START_DEF;  // R6
      cfg_reg.blocking_floor_pct    <= FLOOR_DEF;  // R7
      cfg_reg.dropout_ratio_pct     <= DROP_DEF;   // R8
      cfg_reg.trip_delay_ms         <= DELAY_DEF;  // R10
    end else if (wr_i) begin
      unique case (addr_i)
        ADDR_CTRL: begin
          cfg_reg.operation_selector    <= uvt_oper_e'(wdata_i[CTRL_OPER_LSB +: 2]); // R5
          cfg_reg.start_indication_only <= wdata_i[CTRL_START_ONLY]; // R9
          cfg_reg.line_to_line          <= wdata_i[CTRL_LINE_LINE];  // R12
        end
        ADDR_START_LEVEL: begin
          cfg_reg.start_level_pct <= 8'(clamp16({8'h00, wdata_i[7:0]},
                                                {8'h00, START_MIN}, {8'h00, START_MAX})); // R6
        end
        ADDR_BLOCK_FLOOR: begin
          cfg_reg.blocking_floor_pct <= 8'(clamp16({8'h00, wdata_i[7:0]},
                                                   {8'h00, FLOOR_MIN}, {8'h00, FLOOR_MAX})); // R7
        end
        ADDR_DROPOUT: begin
          cfg_reg.dropout_ratio_pct <= 8'(clamp16({8'h00, wdata_i[7:0]},
                                                  {8'h00, DROP_MIN}, {8'h00, DROP_MAX})); // R8
        end
        ADDR_DELAY: begin
          cfg_reg.trip_delay_ms <= clamp16(wdata_i[15:0], DELAY_MIN, DELAY_MAX); // R10
        end
        default: begin
        end
      endcase
    end
  end

  // not restarted at pickup: cheaper than one
  // divider per phase, at the cost of up to
  // one tick of delay error.
  // 1 ms processing tick; free running so timer accuracy is one tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= '0;    // R16
      tick_reg     <= 1'b1;  // R16
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
      tick_reg     <= 1'b0;
    end
  end

  // products are formed in 32 bits so the
  // largest magnitude times 100 cannot wrap;
  // the floor test is strict, equal blocks.
  // pickup is strict below start level.
  // level comparisons per phase; drop-out level is start times (100+ratio)%
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pickup[i]  = (32'(mag[i]) < level32(cfg_reg.start_level_pct)) &&
                   (32'(mag[i]) > level32(cfg_reg.blocking_floor_pct)); // R1 R7
      hold_ok[i] = ((32'(mag[i]) * PCT_FULL) <=
                    (level32(cfg_reg.start_level_pct) *
                     (PCT_FULL + {24'h00_0000, cfg_reg.dropout_ratio_pct}))) &&
                   (32'(mag[i]) > level32(cfg_reg.blocking_floor_pct)); // R15 R7
    end
  end

  // idle: waits for pickup, timer held at 0.
  // run: counts ticks while the hold region
  // holds; reaching the delay moves to trip.
  // trip: stays until drop-out, so a trip
  // cannot chatter near the start level.
  // per-phase state and delay timer, one copy for each phase
  for (genvar g = 0; g < 3; g++) begin : g_phase
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        phase_reg[g] <= PH_IDLE;
        timer_reg[g] <= 16'h0000;  // R16
      end else if (inhibit) begin
        phase_reg[g] <= PH_IDLE;   // R13 R14
        timer_reg[g] <= 16'h0000;
      end else begin
        unique case (phase_reg[g])
          PH_IDLE: begin
            timer_reg[g] <= 16'h0000;
            if (pickup[g]) begin
              phase_reg[g] <= PH_RUN;  // R1
            end
          end
          PH_RUN: begin
            if (!hold_ok[g]) begin
              phase_reg[g] <= PH_IDLE;  // R15
              timer_reg[g] <= 16'h0000; // R15
            end else if (tick_reg) begin
              timer_reg[g] <= timer_reg[g] + 16'h0001;  // R4 R16
              if ((timer_reg[g] + 16'h0001) >= cfg_reg.trip_delay_ms) begin
                phase_reg[g] <= PH_TRIP;  // R3 R4
              end
            end
          end
          PH_TRIP: begin
            if (!hold_ok[g]) begin
              phase_reg[g] <= PH_IDLE;  // R15
              timer_reg[g] <= 16'h0000;
            end
          end
          default: begin
            phase_reg[g] <= PH_IDLE;
          end
        endcase
      end
    end
    assign started[g] = (phase_reg[g] != PH_IDLE);  // R4
    assign tripped[g] = (phase_reg[g] == PH_TRIP);  // R4 R11
  end

  // off needs no timer but is gated anyway
  // by inhibit, so it never trips
  // ones needed among expired timers for the selected operation
  always_comb begin
    unique case (cfg_reg.operation_selector)
      OPER_ONE_OF_THREE: trips_needed = 2'h1;  // R14
      OPER_TWO_OF_THREE: trips_needed = 2'h2;  // R14
      OPER_ALL:          trips_needed = 2'h3;  // R14
      OPER_OFF:          trips_needed = 2'h0;
    endcase
  end

  // next values of the general flags; phases
  // still time in start-only mode, only the
  // general trip is held back
  assign gen_start_next = !inhibit && (|started);  // R2
  assign gen_trip_next  = !inhibit && !cfg_reg.start_indication_only &&
                          (trips_needed != 2'h0) &&
                          (count3(tripped) >= trips_needed);  // R3 R9 R14

  // flops give glitch free outputs at the
  // cost of one cycle of latency
  // exported flags from flops; per-phase trips are kept off the ports
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= '0;
    end else begin
      flags_o.phase_started     <= inhibit ? 3'h0 : started;  // R11 R14
      flags_o.general_start_out <= gen_start_next;            // R2
      flags_o.general_trip_out  <= gen_trip_next;             // R3
    end
  end

  // comparing next value with the flop finds
  // each edge one cycle early, so the event
  // lands together with the flag itself
  // rises of general start and trip and the fall of general start become interrupt events
  assign events[IRQ_START_RISE] = gen_start_next && !flags_o.general_start_out;
  assign events[IRQ_TRIP_RISE]  = gen_trip_next && !flags_o.general_trip_out;
  assign events[IRQ_START_FALL] = !gen_start_next && flags_o.general_start_out;

  // an event is never lost to a clear racing
  // it; software sees it on the next read
  // write-one-to-clear, a new event in the same cycle wins over the clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_i && (addr_i == ADDR_IRQ_STATUS)) begin
      irq_status_next = irq_status_reg & ~wdata_i[IRQ_W-1:0];
    end
    irq_status_next = irq_status_next | events;
  end

  // the level uses the next status, so a
  // clear drops the interrupt in one edge
  // interrupt status, mask and level output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
      irq_o          <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_i && (addr_i == ADDR_IRQ_MASK)) begin
        irq_mask_reg <= wdata_i[IRQ_W-1:0];
      end
      irq_o <= |(irq_status_next & irq_mask_reg);
    end
  end

  // status shows per-phase trips that are
  // not ports; started and tripped come from
  // state, one cycle ahead of the flags
  // read mux; unmapped addresses read zero
  always_comb begin
    read_word = 32'h0000_0000;
    unique case (addr_i)
      ADDR_CTRL: begin
        read_word[CTRL_OPER_LSB +: 2] = cfg_reg.operation_selector;
        read_word[CTRL_START_ONLY]    = cfg_reg.start_indication_only;
        read_word[CTRL_LINE_LINE]     = cfg_reg.line_to_line;
      end
      ADDR_START_LEVEL: read_word[7:0]  = cfg_reg.start_level_pct;
      ADDR_BLOCK_FLOOR: read_word[7:0]  = cfg_reg.blocking_floor_pct;
      ADDR_DROPOUT:     read_word[7:0]  = cfg_reg.dropout_ratio_pct;
      ADDR_DELAY:       read_word[15:0] = cfg_reg.trip_delay_ms;
      ADDR_STATUS: begin
        read_word[STAT_STARTED_LSB +: 3] = started;  // R4
        read_word[STAT_TRIPPED_LSB +: 3] = tripped;  // R4
        read_word[STAT_GEN_START]        = flags_o.general_start_out;
        read_word[STAT_GEN_TRIP]         = flags_o.general_trip_out;
        read_word[STAT_BLOCKED]          = function_block_in_i;
      end
      ADDR_IRQ_STATUS:  read_word[IRQ_W-1:0] = irq_status_reg;
      ADDR_IRQ_MASK:    read_word[IRQ_W-1:0] = irq_mask_reg;
      default: begin
      end
    endcase
  end

  // zero outside the slot lets several
  // slaves share an or-ed read bus
  // read data valid only in the cycle after the read strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= read_word;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule : uvt_trip

`default_nettype wire

// >>> dv/uvt_src.sv
// partner model: upstream magnitude stage and user block logic.
// assumes the bench sets target magnitudes; one register stage of latency.
`timescale 1ns/10ps
`default_nettype none
module uvt_src (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] set_a_i,
  input  wire logic [15:0] set_b_i,
  input  wire logic [15:0] set_c_i,
  input  wire logic        blk_req_i,
  output var  logic [15:0] mag_a_o,
  output var  logic [15:0] mag_b_o,
  output var  logic [15:0] mag_c_o,
  output var  logic        blk_o
);
  // measurement settles at rated voltage out of reset, so nothing starts early
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mag_a_o <= 16'h6400;
      mag_b_o <= 16'h6400;
      mag_c_o <= 16'h6400;
      blk_o   <= 1'b0;
    end else begin
      mag_a_o <= set_a_i;
      mag_b_o <= set_b_i;
      mag_c_o <= set_c_i;
      blk_o   <= blk_req_i;
    end
  end
endmodule : uvt_src
`default_nettype wire

// >>> dv/uvt_trip_chk.sv
// checker: port-level timing relations of the undervoltage trip block.
// assumes it is bound to uvt_trip and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module uvt_trip_chk
  import uvt_pkg::*;
#(
  parameter int MAG_W       = 16,
  parameter int TICK_CYCLES = 10
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic [MAG_W-1:0] phase_a_magnitude_i,
  input wire logic             function_block_in_i,
  input wire logic [7:0]       addr_i,
  input wire logic [31:0]      wdata_i,
  input wire logic             wr_i,
  input wire logic             rd_i,
  input wire logic [31:0]      rdata_o,
  input wire uvt_flags_s       flags_o,
  input wire logic             irq_o
);
  // two ticks of slack under the bench's 50 ms delay: the free running tick may fire just after pickup
  localparam int MIN_RUN = 48 * TICK_CYCLES;
  logic [3:0] ctrl_reg;
  int         run_cnt;
  // shadow of the control bits, snooped from writes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) ctrl_reg <= 4'h8;
    else if (wr_i && addr_i == ADDR_CTRL) ctrl_reg <= wdata_i[3:0];
  end
  // cycles the general start has stood without a break
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) run_cnt <= 0;
    else run_cnt <= flags_o.general_start_out ? run_cnt + 1 : 0;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_gen_start; flags_o.general_start_out == (|flags_o.phase_started); endproperty
  a_gen_start: assert property (p_gen_start) else $error("general start mismatch");
  property p_block; function_block_in_i [*3] |=> flags_o == '0; endproperty
  a_block: assert property (p_block) else $error("flags while blocked");
  property p_trip_start; flags_o.general_trip_out |-> flags_o.general_start_out; endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  property p_rdata_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_trip_time; $rose(flags_o.general_trip_out) |-> run_cnt >= MIN_RUN; endproperty
  a_trip_time: assert property (p_trip_time) else $error("trip too early");
  property p_oper_off;
    (ctrl_reg[1:0] == 2'b00) && ($past(ctrl_reg[1:0]) == 2'b00)
      && ($past(ctrl_reg[1:0], 2) == 2'b00) |-> flags_o == '0;
  endproperty
  a_oper_off: assert property (p_oper_off) else $error("output with selector off");
  property p_start_only;
    ctrl_reg[2] && $past(ctrl_reg[2]) && $past(ctrl_reg[2], 2) |-> !flags_o.general_trip_out;
  endproperty
  a_start_only: assert property (p_start_only) else $error("trip in start only mode");
  property p_start_win;
    $rose(flags_o.phase_started[0]) |-> ($past(phase_a_magnitude_i, 2) < 16'h8200)
      && ($past(phase_a_magnitude_i, 2) > 16'h0000);
  endproperty
  a_start_win: assert property (p_start_win) else $error("start outside window");
  property p_dropout; $past(phase_a_magnitude_i, 2) > 16'h8F00 |-> !flags_o.phase_started[0];
  endproperty
  a_dropout: assert property (p_dropout) else $error("no drop out");
  c_start: cover property ($rose(flags_o.general_start_out));
  c_trip: cover property ($rose(flags_o.general_trip_out));
  c_irq: cover property ($rose(irq_o));
endmodule : uvt_trip_chk
`default_nettype wire

// >>> dv/uvt_trip_tb.sv
// testbench for uvt_trip: settings, pickup, timing, voting, block, events.
// assumes a short tick so one millisecond is ten clocks.
`timescale 1ns/10ps
`default_nettype none
module uvt_trip_tb;
  import uvt_pkg::*;
  localparam logic [15:0] HI = 16'h6400;
  localparam logic [15:0] LO = 16'h5000;
  logic        clk_i, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, blk_req = 1'b0, blk, irq_o;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [15:0] set_a = HI, set_b = HI, set_c = HI, mag_a, mag_b, mag_c;
  uvt_flags_s  flags_o;
  int          num_errors = 0, total_checks = 0;
  uvt_src u_src (.clk_i(clk_i), .rst_i(rst_i), .set_a_i(set_a), .set_b_i(set_b),
    .set_c_i(set_c), .blk_req_i(blk_req), .mag_a_o(mag_a), .mag_b_o(mag_b),
    .mag_c_o(mag_c), .blk_o(blk));
  uvt_trip #(.MAG_W(16), .TICK_CYCLES(10)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .phase_a_magnitude_i(mag_a), .phase_b_magnitude_i(mag_b), .phase_c_magnitude_i(mag_c),
    .function_block_in_i(blk), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .flags_o(flags_o), .irq_o(irq_o));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cy
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk(what, exp, rdata_o);
  endtask : rchk
  // write, then read back what the clamp should leave
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    wr(a, d);
    rchk(a, exp, "setting");
  endtask : wrc
  task automatic drive(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk_i);
    set_a <= a;
    set_b <= b;
    set_c <= c;
  endtask : drive
  task automatic t_defaults;
    rchk(ADDR_CTRL, 32'h8, "ctrl");
    rchk(ADDR_START_LEVEL, {24'h0, START_DEF}, "start");
    rchk(ADDR_BLOCK_FLOOR, {24'h0, FLOOR_DEF}, "floor");
    rchk(ADDR_DROPOUT, {24'h0, DROP_DEF}, "dropout");
    rchk(ADDR_DELAY, {16'h0, DELAY_DEF}, "delay");
    rchk(ADDR_IRQ_MASK, 32'h0, "mask");
    rchk(8'h20, 32'h0, "unmapped");
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_clamp;
    wrc(ADDR_START_LEVEL, 32'h10, 32'h1E);
    wrc(ADDR_START_LEVEL, 32'h83, 32'h82);
    wrc(ADDR_START_LEVEL, 32'h5A, 32'h5A);
    wrc(ADDR_BLOCK_FLOOR, 32'h15, 32'h14);
    wrc(ADDR_BLOCK_FLOOR, 32'h0A, 32'h0A);
    wrc(ADDR_DROPOUT, 32'h00, 32'h01);
    wrc(ADDR_DROPOUT, 32'h0B, 32'h0A);
    wrc(ADDR_DROPOUT, 32'h05, 32'h05);
    wrc(ADDR_DELAY, 32'hEA61, 32'hEA60);
    wrc(ADDR_DELAY, 32'h31, 32'h32);
    wr(ADDR_STATUS, 32'hFFFF);
    rchk(ADDR_STATUS, 32'h0, "status ro");
    $display("test clamp done");
  endtask : t_clamp
  // pickup, full delay, per-phase status, then events and clear
  task automatic t_start_trip;
    wr(ADDR_IRQ_MASK, 32'h7);
    wr(ADDR_CTRL, 32'h9);
    drive(LO, HI, HI);
    wait_cy(3);
    chk("flags start", 32'h06, flags_o);
    chk("irq start", 32'h1, irq_o);
    wait_cy(470);
    chk("flags early", 32'h06, flags_o);
    wait_cy(40);
    chk("flags trip", 32'h07, flags_o);
    rchk(ADDR_STATUS, 32'hC9, "status");
    rchk(ADDR_IRQ_STATUS, 32'h3, "events");
    wr(ADDR_IRQ_STATUS, 32'h3);
    wait_cy(2);
    chk("irq cleared", 32'h0, irq_o);
    $display("test start trip done");
  endtask : t_start_trip
  // hold region edge: 90 percent raised by 5 percent is 0x5E80
  task automatic t_dropout;
    drive(16'h5E80, HI, HI);
    wait_cy(3);
    chk("flags hold", 32'h07, flags_o);
    drive(16'h5E81, HI, HI);
    wait_cy(3);
    chk("flags drop", 32'h00, flags_o);
    rchk(ADDR_IRQ_STATUS, 32'h4, "fall event");
    chk("irq fall", 32'h1, irq_o);
    wr(ADDR_IRQ_STATUS, 32'h4);
    $display("test dropout done");
  endtask : t_dropout
  task automatic t_floor;
    drive(HI, 16'h0A00, HI);
    wait_cy(3);
    chk("flags floor", 32'h00, flags_o);
    drive(HI, 16'h0A01, HI);
    wait_cy(3);
    chk("flags above floor", 32'h0A, flags_o);
    wr(ADDR_IRQ_MASK, 32'h0);
    wait_cy(2);
    chk("irq masked", 32'h0, irq_o);
    drive(HI, HI, HI);
    wait_cy(4);
    $display("test floor done");
  endtask : t_floor
  task automatic t_vote(input logic [31:0] ctrl, input logic [2:0] low, input logic [31:0] exp);
    wr(ADDR_CTRL, ctrl);
    drive(low[0] ? LO : HI, low[1] ? LO : HI, low[2] ? LO : HI);
    wait_cy(515);
    chk("flags vote", exp, flags_o);
    drive(HI, HI, HI);
    wait_cy(4);
  endtask : t_vote
  task automatic t_block;
    wr(ADDR_CTRL, 32'h9);
    drive(LO, HI, HI);
    wait_cy(3);
    chk("flags before block", 32'h06, flags_o);
    @(posedge clk_i);
    blk_req <= 1'b1;
    wait_cy(4);
    chk("flags blocked", 32'h00, flags_o);
    rchk(ADDR_STATUS, 32'h100, "status blocked");
    @(posedge clk_i);
    blk_req <= 1'b0;
    wait_cy(4);
    chk("flags unblocked", 32'h06, flags_o);
    drive(HI, HI, HI);
    $display("test block done");
  endtask : t_block
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults();
    t_clamp();
    t_start_trip();
    t_dropout();
    t_floor();
    t_vote(32'h0A, 3'b001, 32'h06);
    t_vote(32'h0A, 3'b011, 32'h0F);
    t_vote(32'h0B, 3'b011, 32'h0E);
    t_vote(32'h0B, 3'b111, 32'h1F);
    t_vote(32'h0D, 3'b001, 32'h06);
    t_vote(32'h08, 3'b001, 32'h00);
    $display("test vote done");
    t_block();
    print_verdict();
  end
  // whole run is near 3800 clocks; over five times that means a hang
  initial begin
    #(20000 * 8);
    num_errors++;
    $display("FAIL watchdog expected done seen timeout");
    print_verdict();
  end
endmodule : uvt_trip_tb
bind uvt_trip uvt_trip_chk #(.MAG_W(MAG_W), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .phase_a_magnitude_i(phase_a_magnitude_i),
  .function_block_in_i(function_block_in_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .flags_o(flags_o), .irq_o(irq_o));
`default_nettype wire
